// ### design/adc_seq_consts.vh
// Register offsets, field positions, reset values and timing for the ADC control.
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register byte offsets on the Avalon slave.
`define ADC_CFG_OFS       16'hD004
`define ADC_OFFSET_OFS    16'hD008
`define ADC_GAIN_OFS      16'hD00C
`define SAMPLE_DMA_CONFIG_OFS    16'hD010
`define ADC_DMASTAT_OFS   16'hD014
`define ADC_DMABASE_OFS   16'hD018
`define ADC_DMALEN_OFS    16'hD01C
`define ADC_DMACUR_OFS    16'hD020
`define ADC_DMACNT_OFS    16'hD024
`define ADC_FLAGS_OFS     16'hA810
`define ADC_ENABLES_OFS   16'hA850

// Conversion configuration fields.
`define ADC_PERIOD_MSB    15
`define ADC_PERIOD_LSB    13
`define ADC_POS_RANGE_BIT 12
`define ADC_NEG_RANGE_BIT 11
`define ADC_POS_SEL_MSB   10
`define ADC_POS_SEL_LSB   7
`define ADC_NEG_SEL_MSB   6
`define ADC_NEG_SEL_LSB   3
`define ADC_SLOW_CLK_BIT  2
`define ADC_ENABLE_BIT    0
`define ADC_CFG_MASK      32'h0000FFFD

// Sample DMA configuration and status fields.
`define ADC_DMA_RESET_BIT 4
`define ADC_DMA_WRAP_BIT  1
`define ADC_DMA_GO_BIT    0
`define ADC_DMA_OVF_BIT   1
`define ADC_DMA_ACT_BIT   0

// Event flag and enable positions.
`define ADC_EV_OVF_BIT    4
`define ADC_EV_SAT_BIT    3
`define ADC_EV_FULL_BIT   2
`define ADC_EV_HALF_BIT   1

// Reset values.
`define ADC_CFG_RST       32'h00001800
`define ADC_GAIN_RST      16'h8000
`define ADC_RAM_BASE      32'h20000000

// Input selector code that stands for no connection.
`define ADC_SEL_NC        4'hF

// Analog settling time and the clock rate it is counted at.
`define ADC_SETTLE_NS     21000
`define ADC_CLK_MHZ       40
`define ADC_SETTLE_CYC    ((`ADC_SETTLE_NS * `ADC_CLK_MHZ + 999) / 1000)

`endif

// ### design/adc_seq_ctrl.v
// ADC sequencing, correction, sample DMA and event control with Avalon slave.
// What this block does
// - With enable set, conversions run back to back until enable is cleared.
// - Enabling from disabled waits the analog settling time before converting.
// - First enable or any config write while running discards one conversion.
// - A processor oscillator switch repeats the discard of one conversion.
// - First result after enable takes settling time plus two sample times.
// - Config writes never stop the sample DMA.
// - A result ready while the DMA is inactive sets the overflow flag.
// - Gain product outside signed 16-bit range sets the saturation flag.
// - DMA write to the last buffer location sets the full flag.
// - DMA write to the last location of the first half sets half flag.
// - Writing one clears an event flag; writing zero leaves it.
// - Interrupt is raised only by pending flags whose enable bit is one.
// - Period code 0..7 selects 32 to 4096 sample clocks per conversion.
// - Range bits enable the positive and negative input buffers when one.
// - Positive selector maps six pins and four internal sources, rest reserved.
// - Negative selector uses the positive selector encoding.
// - Clock select bit picks 6 MHz when zero and 1 MHz when one.
// - Configuration bit 0 starts conversions when one and stops when zero.
// - A signed 16-bit offset is added to each raw result before gain.
// - Gain is unsigned 1.15 fixed point with unity as reset value.
// - Wrap mode restarts at buffer start; linear mode stops when full.
`timescale 1ns/1ps
`include "adc_seq_consts.vh"

module adc_seq_ctrl #(
  parameter SETTLE_CYC = `ADC_SETTLE_CYC
) (
  // Clock and reset.
  input wire clk_in,
  input wire nrst_in,
  // Avalon-MM register slave.
  input wire [15:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Sample clock ticks and oscillator switch, all on clk_in.
  input wire tick_6mhz_in,
  input wire tick_1mhz_in,
  input wire osc_switch_in,
  // Analog conversion core.
  input wire [15:0] raw_sample_in,
  output reg analog_enable_out,
  output reg conv_start_out,
  output reg pos_range_sel_out,
  output reg neg_range_sel_out,
  output reg [3:0] pos_input_sel_out,
  output reg [3:0] neg_input_sel_out,
  output reg slow_sample_clk_sel_out,
  // Sample DMA write port into RAM.
  output reg dma_wr_out,
  output reg [13:0] dma_addr_out,
  output reg [15:0] dma_data_out,
  // Converter interrupt request.
  output wire irq_out
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;
  localparam [15:0] SETTLE_LAST = SETTLE_CYC - 1;

  // Merges write data into an old value under the byte enables.
  function [31:0] adc_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        adc_merge[i*8 +: 8] = be[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
      end
    end
  endfunction

  // Sample clocks per conversion for a period code.
  function [12:0] adc_period_clocks;
    input [2:0] code;
    begin
      case (code)
        3'h0: adc_period_clocks = 13'h0020;
        3'h1: adc_period_clocks = 13'h0040;
        3'h2: adc_period_clocks = 13'h0080;
        3'h3: adc_period_clocks = 13'h0100;
        3'h4: adc_period_clocks = 13'h0200;
        3'h5: adc_period_clocks = 13'h0400;
        3'h6: adc_period_clocks = 13'h0800;
        default: adc_period_clocks = 13'h1000;
      endcase
    end
  endfunction

  // Reserved selector codes are steered to no connection.
  function [3:0] adc_sel_decode;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: adc_sel_decode = code;
        4'h8, 4'h9, 4'hA, 4'hB: adc_sel_decode = code;
        default: adc_sel_decode = `ADC_SEL_NC;
      endcase
    end
  endfunction

  reg ack;
  reg [31:0] cfg;
  reg [15:0] ofs;
  reg [15:0] gain;
  reg wrap;
  reg [13:1] base;
  reg [12:0] size;
  reg [13:1] cur;
  reg [12:0] cnt;
  reg dma_active;
  reg dma_ovf;
  reg [4:1] flags;
  reg [4:1] enables;
  reg [1:0] state;
  reg [15:0] settle_cnt;
  reg [12:0] tick_cnt;
  reg discard;
  reg [31:0] rd_mux;
  reg [31:0] old_word;

  wire req = avs_read_in | avs_write_in;
  wire wr = avs_write_in & ack;
  wire [31:0] merged = adc_merge(old_word, avs_writedata_in,
                                 avs_byteenable_in);
  wire wr_cfg = wr & (avs_address_in == `ADC_CFG_OFS);
  wire wr_dmacfg = wr & (avs_address_in == `SAMPLE_DMA_CONFIG_OFS);
  wire wr_flags = wr & (avs_address_in == `ADC_FLAGS_OFS);
  wire enable = cfg[`ADC_ENABLE_BIT];
  wire tick = cfg[`ADC_SLOW_CLK_BIT] ? tick_1mhz_in : tick_6mhz_in;
  wire [12:0] period = adc_period_clocks(cfg[`ADC_PERIOD_MSB:`ADC_PERIOD_LSB]);
  wire restart = wr_cfg | osc_switch_in;
  wire conv_end = (state == ST_CONV) & ~restart & tick &
                  (tick_cnt == period - 13'h0001);
  wire res_done = conv_end & ~discard;

  // Offset then gain correction with clamping.
  wire signed [16:0] sum = {raw_sample_in[15], raw_sample_in} +
                           {ofs[15], ofs};
  wire signed [17:0] gain_s = {2'b00, gain};
  wire signed [34:0] prod = sum * gain_s;
  wire [19:0] scaled = prod[34:15];
  wire sat_hi = ~scaled[19] & (|scaled[18:15]);
  wire sat_lo = scaled[19] & ~(&scaled[18:15]);
  wire sat = sat_hi | sat_lo;
  wire [15:0] corr = sat_hi ? 16'h7FFF :
                     (sat_lo ? 16'h8000 : scaled[15:0]);

  // DMA progress terms.
  wire [12:0] next_cnt = cnt + 13'h0001;
  wire hit_full = (next_cnt == size);
  wire hit_half = (next_cnt == {1'b0, size[12:1]}) & (|size[12:1]);
  wire ev_ovf = res_done & ~dma_active;
  wire ev_sat = res_done & sat;
  wire ev_full = res_done & dma_active & hit_full;
  wire ev_half = res_done & dma_active & hit_half;
  wire [4:1] ev = {ev_ovf, ev_sat, ev_full, ev_half};
  wire [4:1] clr = wr_flags ? merged[4:1] : 4'h0;

  assign avs_waitrequest_out = req & ~ack;
  assign irq_out = |(flags & enables);

  always @* begin
    rd_mux = 32'h00000000;
    case (avs_address_in)
      `ADC_CFG_OFS: rd_mux = cfg;
      `ADC_OFFSET_OFS: rd_mux = {16'h0000, ofs};
      `ADC_GAIN_OFS: rd_mux = {16'h0000, gain};
      `SAMPLE_DMA_CONFIG_OFS: rd_mux = {30'h00000000, wrap, 1'b0};
      `ADC_DMASTAT_OFS: rd_mux = {30'h00000000, dma_ovf, dma_active};
      `ADC_DMABASE_OFS: rd_mux = `ADC_RAM_BASE | {18'h00000, base, 1'b0};
      `ADC_DMALEN_OFS: rd_mux = {19'h00000, size};
      `ADC_DMACUR_OFS: rd_mux = `ADC_RAM_BASE | {18'h00000, cur, 1'b0};
      `ADC_DMACNT_OFS: rd_mux = {19'h00000, cnt};
      `ADC_FLAGS_OFS: rd_mux = {27'h0000000, flags, 1'b0};
      `ADC_ENABLES_OFS: rd_mux = {27'h0000000, enables, 1'b0};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Write-side view of the old word; read-only RAM base bits read as zero.
  always @* begin
    old_word = rd_mux;
    if ((avs_address_in == `ADC_DMABASE_OFS) ||
        (avs_address_in == `ADC_DMACUR_OFS)) begin
      old_word = {18'h00000, rd_mux[13:0]};
    end
  end

  // Bus handshake: one wait cycle, then the access completes.
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      ack <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (avs_read_in & ~ack) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // Software-only registers.
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg <= `ADC_CFG_RST;
      ofs <= 16'h0000;
      gain <= `ADC_GAIN_RST;
      wrap <= 1'b0;
      base <= 13'h0000;
      size <= 13'h0000;
      enables <= 4'h0;
    end else if (wr) begin
      case (avs_address_in)
        `ADC_CFG_OFS: cfg <= merged & `ADC_CFG_MASK;
        `ADC_OFFSET_OFS: ofs <= merged[15:0];
        `ADC_GAIN_OFS: gain <= merged[15:0];
        `SAMPLE_DMA_CONFIG_OFS: wrap <= merged[`ADC_DMA_WRAP_BIT];
        `ADC_DMABASE_OFS: base <= merged[13:1];
        `ADC_DMALEN_OFS: size <= merged[12:0];
        `ADC_ENABLES_OFS: enables <= merged[4:1];
        default: cfg <= cfg;
      endcase
    end
  end

  // Analog core controls follow the configuration.
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      pos_range_sel_out <= 1'b0;
      neg_range_sel_out <= 1'b0;
      pos_input_sel_out <= 4'h0;
      neg_input_sel_out <= 4'h0;
      slow_sample_clk_sel_out <= 1'b0;
      analog_enable_out <= 1'b0;
    end else begin
      pos_range_sel_out <= cfg[`ADC_POS_RANGE_BIT];
      neg_range_sel_out <= cfg[`ADC_NEG_RANGE_BIT];
      pos_input_sel_out <= adc_sel_decode(
        cfg[`ADC_POS_SEL_MSB:`ADC_POS_SEL_LSB]);
      neg_input_sel_out <= adc_sel_decode(
        cfg[`ADC_NEG_SEL_MSB:`ADC_NEG_SEL_LSB]);
      slow_sample_clk_sel_out <= cfg[`ADC_SLOW_CLK_BIT];
      analog_enable_out <= enable;
    end
  end

  // Conversion sequencer: settle, then convert continuously.
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      settle_cnt <= 16'h0000;
      tick_cnt <= 13'h0000;
      discard <= 1'b1;
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      if (!enable) begin
        state <= ST_IDLE;
        discard <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_SETTLE;
            settle_cnt <= 16'h0000;
            discard <= 1'b1;
          end
          ST_SETTLE: begin
            settle_cnt <= settle_cnt + 16'h0001;
            if (settle_cnt == SETTLE_LAST) begin
              state <= ST_CONV;
              tick_cnt <= 13'h0000;
              conv_start_out <= 1'b1;
            end
          end
          ST_CONV: begin
            if (restart) begin
              tick_cnt <= 13'h0000;
              discard <= 1'b1;
              conv_start_out <= 1'b1;
            end else if (conv_end) begin
              tick_cnt <= 13'h0000;
              discard <= 1'b0;
              conv_start_out <= 1'b1;
            end else if (tick) begin
              tick_cnt <= tick_cnt + 13'h0001;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Sample DMA and event flags; config writes leave the DMA running.
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      dma_active <= 1'b0;
      dma_ovf <= 1'b0;
      cur <= 13'h0000;
      cnt <= 13'h0000;
      flags <= 4'h0;
      dma_wr_out <= 1'b0;
      dma_addr_out <= 14'h0000;
      dma_data_out <= 16'h0000;
    end else begin
      dma_wr_out <= 1'b0;
      flags <= (flags & ~clr) | ev;
      if (ev_ovf) begin
        dma_ovf <= 1'b1;
      end
      if (res_done & dma_active) begin
        dma_wr_out <= 1'b1;
        dma_addr_out <= {cur, 1'b0};
        dma_data_out <= corr;
        if (hit_full) begin
          cur <= base;
          cnt <= wrap ? 13'h0000 : next_cnt;
          dma_active <= wrap;
        end else begin
          cur <= cur + 13'h0001;
          cnt <= next_cnt;
        end
      end
      if (wr_dmacfg & merged[`ADC_DMA_RESET_BIT]) begin
        dma_active <= 1'b0;
        dma_ovf <= 1'b0;
        cur <= base;
        cnt <= 13'h0000;
      end else if (wr_dmacfg & merged[`ADC_DMA_GO_BIT]) begin
        dma_active <= 1'b1;
        cur <= base;
        cnt <= 13'h0000;
      end
    end
  end

endmodule // adc_seq_ctrl

// ### verif/asc_core.sv
// Behavioural analog core with sample clock ticks and a DMA target RAM.
`timescale 1ns/1ps
module asc_core (
  // Clock.
  input wire clk_in,
  // Analog conversion core.
  input wire analog_enable_in,
  input wire [15:0] sample_in,
  output logic tick_fast_out = 1'b0,
  output logic tick_slow_out = 1'b0,
  output wire [15:0] raw_out,
  // DMA write port.
  input wire dma_wr_in,
  input wire [13:0] dma_addr_in,
  input wire [15:0] dma_data_in
);
  logic [15:0] mem [0:8191];
  logic [5:0] div = 6'h00;
  // Six fast ticks and one slow tick in every 40 system clocks.
  always @(posedge clk_in) begin
    div <= (div == 6'h27) ? 6'h00 : div + 6'h01;
    tick_fast_out <= (div % 7 == 0);
    tick_slow_out <= (div == 6'h00);
  end
  // A powered-down core shows a changed value, not the last sample.
  assign raw_out = analog_enable_in ? sample_in : ~sample_in;
  always @(posedge clk_in) begin
    if (dma_wr_in) begin
      mem[dma_addr_in[13:1]] <= dma_data_in;
    end
  end
endmodule // asc_core

// ### verif/asc_monitor.sv
// Checker for the ADC control ports.
`timescale 1ns/1ps
module asc_monitor #(
  parameter SETTLE_CYC = 4
) (
  // Clock and reset.
  input wire clk_in,
  input wire nrst_in,
  // Register bus.
  input wire [15:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire avs_waitrequest_out,
  // Converter controls.
  input wire analog_enable_out,
  input wire conv_start_out,
  input wire pos_range_sel_out,
  input wire neg_range_sel_out,
  input wire [3:0] pos_input_sel_out,
  input wire [3:0] neg_input_sel_out,
  input wire slow_sample_clk_sel_out
);
  localparam int SMAX = SETTLE_CYC + 4;
  wire cfg_wr = avs_write_in && !avs_waitrequest_out &&
    avs_address_in == 16'hD004 && avs_byteenable_in == 4'hF;
  wire [31:0] wd = avs_writedata_in;
  function automatic logic [3:0] smap(input logic [3:0] c);
    return (c < 4'h6 || (c > 4'h7 && c < 4'hC)) ? c : 4'hF;
  endfunction
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_settle_hold: assert property (
    $rose(analog_enable_out) |-> !conv_start_out [*3])
    else $error("conversion started while settling");
  a_settle_bound: assert property (
    $rose(analog_enable_out) |-> ##[1:SMAX] conv_start_out)
    else $error("no conversion after settling");
  a_stop_quiet: assert property (
    !analog_enable_out [*2] |-> !conv_start_out)
    else $error("conversion while disabled");
  a_range_bits: assert property (
    cfg_wr |-> ##2 {pos_range_sel_out, neg_range_sel_out} ==
    $past(wd[12:11], 2))
    else $error("range select wrong");
  a_clock_sel: assert property (
    cfg_wr |-> ##2 slow_sample_clk_sel_out == $past(wd[2], 2))
    else $error("sample clock select wrong");
  a_pos_sel: assert property (
    cfg_wr |-> ##2 pos_input_sel_out == smap($past(wd[10:7], 2)))
    else $error("positive input select wrong");
  a_neg_sel: assert property (
    cfg_wr |-> ##2 neg_input_sel_out == smap($past(wd[6:3], 2)))
    else $error("negative input select wrong");
  a_enable_follow: assert property (
    cfg_wr |-> ##2 analog_enable_out == $past(wd[0], 2))
    else $error("enable does not follow");
endmodule // asc_monitor
bind adc_seq_ctrl asc_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_asc_monitor (
  .clk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out,
  .analog_enable_out, .conv_start_out, .pos_range_sel_out,
  .neg_range_sel_out, .pos_input_sel_out, .neg_input_sel_out,
  .slow_sample_clk_sel_out
);

// ### verif/adc_sequencing_and_event_control_test.sv
// Self-checking bench for the ADC sequencing and event control.
`timescale 1ns/1ps
module adc_sequencing_and_event_control_test;
  logic clk_in = 1'b0, nrst_in = 1'b0, avs_read_in = 1'b0;
  logic avs_write_in = 1'b0, osc_switch_in = 1'b0;
  logic [15:0] avs_address_in = 16'h0000, smp = 16'h0000, ofs;
  logic [31:0] avs_writedata_in = 32'h0, rng = 32'h461C005F, q;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, tick_6mhz_in, tick_1mhz_in, irq_out;
  logic analog_enable_out, conv_start_out, pos_range_sel_out;
  logic neg_range_sel_out, slow_sample_clk_sel_out, dma_wr_out;
  logic [3:0] pos_input_sel_out, neg_input_sel_out;
  logic [13:0] dma_addr_out;
  logic [15:0] raw_sample_in, dma_data_out;
  int err_total = 0, comparisons = 0, n, i, g;
  adc_seq_ctrl #(.SETTLE_CYC(4)) u_adc_seq_ctrl (.clk_in(clk_in),
    .nrst_in(nrst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .tick_6mhz_in(tick_6mhz_in), .tick_1mhz_in(tick_1mhz_in),
    .osc_switch_in(osc_switch_in), .raw_sample_in(raw_sample_in),
    .analog_enable_out(analog_enable_out),
    .conv_start_out(conv_start_out),
    .pos_range_sel_out(pos_range_sel_out),
    .neg_range_sel_out(neg_range_sel_out),
    .pos_input_sel_out(pos_input_sel_out),
    .neg_input_sel_out(neg_input_sel_out),
    .slow_sample_clk_sel_out(slow_sample_clk_sel_out),
    .dma_wr_out(dma_wr_out), .dma_addr_out(dma_addr_out),
    .dma_data_out(dma_data_out), .irq_out(irq_out));
  asc_core u_asc_core (.clk_in, .analog_enable_in(analog_enable_out),
    .sample_in(smp), .tick_fast_out(tick_6mhz_in),
    .tick_slow_out(tick_1mhz_in), .raw_out(raw_sample_in),
    .dma_wr_in(dma_wr_out), .dma_addr_in(dma_addr_out),
    .dma_data_in(dma_data_out));
  initial forever #12.5 clk_in = ~clk_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] smap(input logic [3:0] c);
    return (c < 4'h6 || (c > 4'h7 && c < 4'hC)) ? c : 4'hF;
  endfunction
  task automatic tally_and_finish;
    $display("mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input int k, lim);
    if (k >= lim) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a,
      input logic [31:0] d);
    int k;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    hang(k, 20);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [15:0] a,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic cs;
    int k;
    for (k = 0; k < 999; k++) begin
      @(negedge clk_in);
      if (conv_start_out === 1'b1) break;
    end
    hang(k, 999);
  endtask
  // Counts fast ticks up to the next DMA write and checks that write.
  task automatic lat(input bit st, input int et, input logic [13:0] ea,
      input logic [15:0] ed);
    int k;
    n = 0;
    if (st) cs();
    for (k = 0; k < 9999; k++) begin
      @(negedge clk_in);
      if (dma_wr_out === 1'b1) break;
      n += tick_6mhz_in;
    end
    hang(k, 9999);
    if (et > 0) chk("ticks", (n + 1) >> 1, et >> 1);
    chk("addr", dma_addr_out, ea);
    chk("data", dma_data_out, ed);
    @(posedge clk_in);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    rd("cfg", 16'hD004, 32'h1800);
    rd("gain", 16'hD00C, 32'h8000);
    rd("unmapped", 16'hD000, 32'h0);
    for (i = 0; i < 4; i++) begin
      rng = lfsr(rng);
      wr(16'hD004, rng & 32'hFFFC);
      @(negedge clk_in);
      chk("range", {pos_range_sel_out, neg_range_sel_out}, rng[12:11]);
      chk("clock", slow_sample_clk_sel_out, rng[2]);
      chk("psel", pos_input_sel_out, smap(rng[10:7]));
      chk("nsel", neg_input_sel_out, smap(rng[6:3]));
      @(posedge clk_in);
      rd("cfg", 16'hD004, rng & 32'hFFFC);
    end
    wr(16'hA850, 32'h0);
    wr(16'hD010, 32'h10);
    wr(16'hD018, 32'h100);
    wr(16'hD01C, 32'h2);
    ofs = 16'(2 * (57344 - (32'hE000 - rng[5:0])));
    g = (32768 * 16384) / (16'sh2000 - 16'shE000);
    wr(16'hD008, ofs);
    wr(16'hD00C, g);
    wr(16'hA810, 32'h1E);
    wr(16'hD010, 32'h1);
    smp <= 16'(rng[29:16]);
    wr(16'hD004, 32'hC9);
    lat(1'b1, 64, 14'h100, smp + ofs);
    rd("flags", 16'hA810, 32'h2);
    chk("irq", irq_out, 1'b0);
    lat(1'b0, 0, 14'h102, smp + ofs);
    rd("flags", 16'hA810, 32'h6);
    rd("count", 16'hD024, 32'h2);
    cs();
    @(posedge clk_in);
    rd("flags", 16'hA810, 32'h16);
    wr(16'hA810, 32'h0);
    rd("flags", 16'hA810, 32'h16);
    wr(16'hA850, 32'h4);
    chk("irq", irq_out, 1'b1);
    wr(16'hA810, 32'h4);
    rd("flags", 16'hA810, 32'h12);
    chk("irq", irq_out, 1'b0);
    wr(16'hD010, 32'h10);
    wr(16'hD01C, 32'h1);
    wr(16'hD010, 32'h3);
    wr(16'hA810, 32'h10);
    wr(16'hD00C, 32'hFFFF);
    smp <= 16'h7000;
    wr(16'hD004, 32'h20C9);
    lat(1'b0, 128, 14'h100, 16'h7FFF);
    rd("flags", 16'hA810, 32'hE);
    rd("status", 16'hD014, 32'h1);
    rd("cur", 16'hD020, 32'h20000100);
    smp <= 16'h9000;
    lat(1'b0, 0, 14'h100, 16'h8000);
    rd("status", 16'hD014, 32'h1);
    chk("ram", u_asc_core.mem[13'h80], 16'h8000);
    osc_switch_in <= 1'b1;
    @(posedge clk_in);
    osc_switch_in <= 1'b0;
    lat(1'b0, 128, 14'h100, 16'h8000);
    wr(16'hD004, 32'h20C8);
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_in);
      n += dma_wr_out;
    end
    chk("writes", n, 0);
    tally_and_finish();
  end
endmodule // adc_sequencing_and_event_control_test
